// ---- logic/dir_defs.vh ----
// constants for the display identification store and its serial port
// assumes a 100 MHz sys_clk that oversamples the two-wire link pins
`ifndef DIR_DEFS_VH
`define DIR_DEFS_VH
`define DIR_DEV_ADDR 7'h50
`define DIR_ROM_AW 7
`define DIR_LAST_ADDR 7'h7F
`define DIR_BYTE_W 8
`define DIR_FIFO_DEPTH 16
`define DIR_FIFO_AW 4
`define DIR_BIT_LAST 4'h7
`define DIR_BIT_FULL 4'h8
`define DIR_SCL_STD_KHZ 100
`define DIR_SCL_FAST_KHZ 400
`define DIR_IDLE_BYTE 8'hFF
`endif

// ---- logic/dir_fifo.v ----
// small synchronous fifo with flush
// assumes both sides on sys_clk; flush wins over a push
`timescale 1ns/1ps
module dir_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire reset,
  input wire flush,
  input wire wr_valid,
  output wire wr_ready,
  input wire [W-1:0] wr_data,
  output wire rd_valid,
  input wire rd_ready,
  output wire [W-1:0] rd_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  // sized increments keep the pointer and count arithmetic exact
  localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};
  wire push = wr_valid & wr_ready & ~flush;
  wire pop = rd_valid & rd_ready & ~flush;
  assign wr_ready = (cnt_q != D[AW:0]);
  assign rd_valid = (cnt_q != {(AW+1){1'b0}});
  assign rd_data = mem[rp_q];
  always @(posedge sys_clk) begin
    if (push) mem[wp_q] <= wr_data;
  end
  always @(posedge sys_clk) begin
    if (reset || flush) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_q <= wp_q + PTR_ONE;
      if (pop) rp_q <= rp_q + PTR_ONE;
      if (push && !pop) cnt_q <= cnt_q + CNT_ONE;
      else if (pop && !push) cnt_q <= cnt_q - CNT_ONE;
    end
  end
endmodule // dir_fifo

// ---- logic/dir_id_rom.v ----
// 128-byte display identification store behind a two-wire read port
// assumes link pins arrive unsynchronised and an external pull-up
`timescale 1ns/1ps
`include "dir_defs.vh"
module dir_id_rom #(
  // arbitrary identity values
  parameter [15:0] VENDOR_ID = 16'h1234,
  parameter [15:0] PRODUCT_CODE = 16'h0001,
  parameter [47:0] MODEL_TEXT = "PANEL1"
) (
  input wire sys_clk,
  input wire reset,
  input wire id_store_supply,
  input wire id_store_serial_clk,
  input wire id_store_serial_data_i,
  output reg id_store_serial_data_o,
  output reg id_store_serial_data_oe,
  output reg id_store_busy
);
  localparam [71:0] NAME_TEXT = "Color LCD";
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEV = 3'd1;
  localparam [2:0] ST_ACKW = 3'd2;
  localparam [2:0] ST_ACK = 3'd3;
  localparam [2:0] ST_WADR = 3'd4;
  localparam [2:0] ST_WDAT = 3'd5;
  localparam [2:0] ST_TX = 3'd6;
  localparam [2:0] ST_MACK = 3'd7;
  localparam [1:0] K_DEV = 2'd0;
  localparam [1:0] K_WADR = 2'd1;
  localparam [1:0] K_WDAT = 2'd2;

  function [7:0] txt_byte;
    input [71:0] t;
    input [6:0] back;
    reg [71:0] s;
    begin
      s = t >> {back, 3'b000};
      txt_byte = s[7:0];
    end
  endfunction

  function [7:0] rom_raw;
    input [6:0] a;
    begin
      rom_raw = 8'h00;
      if (a >= 7'h01 && a <= 7'h06)
        rom_raw = 8'hFF;
      else if (a >= 7'h26 && a <= 7'h35)
        rom_raw = 8'h01;
      else if ((a >= 7'h53 && a <= 7'h59) ||
               (a >= 7'h65 && a <= 7'h6B))
        rom_raw = 8'h20;
      else if (a >= 7'h7B && a <= 7'h7D)
        rom_raw = 8'h20;
      else if (a >= 7'h4D && a <= 7'h52)
        rom_raw = txt_byte({24'h00_0000, MODEL_TEXT},
          7'h52 - a);
      else if (a >= 7'h5F && a <= 7'h64)
        rom_raw = txt_byte({24'h00_0000, MODEL_TEXT},
          7'h64 - a);
      else if (a >= 7'h71 && a <= 7'h79)
        rom_raw = txt_byte(NAME_TEXT, 7'h79 - a);
      else begin
        case (a)
          7'h08: rom_raw = VENDOR_ID[15:8];
          7'h09: rom_raw = VENDOR_ID[7:0];
          7'h0A: rom_raw = PRODUCT_CODE[7:0];
          7'h0B: rom_raw = PRODUCT_CODE[15:8];
          7'h10: rom_raw = 8'h0E;
          7'h11: rom_raw = 8'h0E;
          7'h12: rom_raw = 8'h01;
          7'h13: rom_raw = 8'h03;
          7'h14: rom_raw = 8'h80;
          7'h15: rom_raw = 8'h1C;
          7'h16: rom_raw = 8'h15;
          7'h17: rom_raw = 8'h78;
          7'h18: rom_raw = 8'h0A;
          7'h19: rom_raw = 8'h34;
          7'h1A: rom_raw = 8'h85;
          7'h1B: rom_raw = 8'h92;
          7'h1C: rom_raw = 8'h55;
          7'h1D: rom_raw = 8'h53;
          7'h1E: rom_raw = 8'h92;
          7'h1F: rom_raw = 8'h26;
          7'h20: rom_raw = 8'h20;
          7'h21: rom_raw = 8'h50;
          7'h22: rom_raw = 8'h54;
          7'h24: rom_raw = 8'h08;
          7'h36: rom_raw = 8'h64;
          7'h37: rom_raw = 8'h19;
          7'h39: rom_raw = 8'h40;
          7'h3A: rom_raw = 8'h41;
          7'h3C: rom_raw = 8'h26;
          7'h3D: rom_raw = 8'h30;
          7'h3E: rom_raw = 8'h18;
          7'h3F: rom_raw = 8'h88;
          7'h40: rom_raw = 8'h36;
          7'h42: rom_raw = 8'h1D;
          7'h43: rom_raw = 8'hD6;
          7'h44: rom_raw = 8'h10;
          7'h47: rom_raw = 8'h18;
          7'h4B: rom_raw = 8'hFE;
          7'h5D: rom_raw = 8'hFE;
          7'h6F: rom_raw = 8'hFC;
          7'h7A: rom_raw = 8'h0A;
          default: rom_raw = 8'h00;
        endcase
      end
    end
  endfunction

  // checksum folds in whatever identity values are configured
  function [7:0] rom_csum;
    input dummy;
    integer i;
    reg [7:0] s;
    begin
      s = 8'h00;
      for (i = 0; i < 127; i = i + 1)
        s = s + rom_raw(i[6:0]);
      rom_csum = 8'h00 - s;
    end
  endfunction

  localparam [7:0] CSUM = rom_csum(1'b0);

  function [7:0] rom_byte;
    input [6:0] a;
    begin
      if (a == `DIR_LAST_ADDR)
        rom_byte = CSUM;
      else
        rom_byte = rom_raw(a);
    end
  endfunction

  // pin synchronisers; stage 0 feeds only stage 1
  reg [2:0] scl_q;
  reg [2:0] sda_q;
  reg [1:0] pwr_q;
  always @(posedge sys_clk) begin
    if (reset) begin
      scl_q <= 3'b111;
      sda_q <= 3'b111;
      pwr_q <= 2'b00;
    end else begin
      scl_q <= {scl_q[1:0], id_store_serial_clk};
      sda_q <= {sda_q[1:0], id_store_serial_data_i};
      pwr_q <= {pwr_q[0], id_store_supply};
    end
  end

  // 10 ns sampling resolves the 400 kHz fast clock easily
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire sda_in = sda_q[1];
  wire bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire bus_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  wire pwr_ok = pwr_q[1];

  reg [2:0] st_q;
  reg [1:0] kind_q;
  reg [3:0] bit_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg rw_q;
  reg [6:0] pf_addr_q;
  reg flush_q;
  reg [6:0] flush_addr_q;

  wire [7:0] rx_next = {rx_q[6:0], sda_in};
  wire do_load = pwr_ok && scl_fall && !bus_start && !bus_stop &&
    ((st_q == ST_ACK && kind_q == K_DEV && rw_q) ||
     (st_q == ST_MACK && bit_q == `DIR_BIT_FULL));

  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire [7:0] fifo_rd_data;

  // prefetch runs ahead of the shifter and stalls when the fifo fills
  dir_fifo #(
    .W(`DIR_BYTE_W),
    .D(`DIR_FIFO_DEPTH),
    .AW(`DIR_FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .flush(flush_q),
    .wr_valid(1'b1),
    .wr_ready(fifo_wr_ready),
    .wr_data(rom_byte(pf_addr_q)),
    .rd_valid(fifo_rd_valid),
    .rd_ready(do_load),
    .rd_data(fifo_rd_data)
  );

  wire [7:0] load_byte = fifo_rd_valid ? fifo_rd_data : `DIR_IDLE_BYTE;

  always @(posedge sys_clk) begin
    if (reset) begin
      pf_addr_q <= 7'h00;
    end else if (flush_q) begin
      pf_addr_q <= flush_addr_q;
    end else if (fifo_wr_ready) begin
      pf_addr_q <= pf_addr_q + 7'h01;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      st_q <= ST_IDLE;
      kind_q <= K_DEV;
      bit_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      flush_q <= 1'b0;
      flush_addr_q <= 7'h00;
      id_store_serial_data_o <= 1'b0;
      id_store_serial_data_oe <= 1'b0;
      id_store_busy <= 1'b0;
    end else begin
      flush_q <= 1'b0;
      id_store_serial_data_o <= 1'b0;
      id_store_busy <= (st_q != ST_IDLE);
      if (!pwr_ok || bus_stop) begin
        st_q <= ST_IDLE;
        id_store_serial_data_oe <= 1'b0;
      end else if (bus_start) begin
        st_q <= ST_DEV;
        bit_q <= 4'h0;
        id_store_serial_data_oe <= 1'b0;
      end else if (do_load) begin
        tx_q <= load_byte;
        bit_q <= 4'h0;
        id_store_serial_data_oe <= ~load_byte[7];
        st_q <= ST_TX;
      end else begin
        case (st_q)
          ST_DEV, ST_WADR, ST_WDAT: begin
            if (scl_rise) begin
              rx_q <= rx_next;
              bit_q <= bit_q + 4'h1;
              if (bit_q == `DIR_BIT_LAST) begin
                st_q <= ST_ACKW;
                if (st_q == ST_DEV) begin
                  kind_q <= K_DEV;
                  rw_q <= sda_in;
                  if (rx_next[7:1] != `DIR_DEV_ADDR)
                    st_q <= ST_IDLE;
                end else if (st_q == ST_WADR) begin
                  kind_q <= K_WADR;
                  flush_addr_q <= rx_next[6:0];
                  flush_q <= 1'b1;
                end else begin
                  kind_q <= K_WDAT;
                end
              end
            end
          end
          ST_ACKW: begin
            if (scl_fall) begin
              id_store_serial_data_oe <= 1'b1;
              st_q <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              id_store_serial_data_oe <= 1'b0;
              bit_q <= 4'h0;
              // the store is read-only: written data is taken and dropped
              st_q <= (kind_q == K_DEV) ? ST_WADR : ST_WDAT;
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall) begin
              if (bit_q == `DIR_BIT_FULL) begin
                id_store_serial_data_oe <= 1'b0;
                st_q <= ST_MACK;
                bit_q <= 4'h0;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                id_store_serial_data_oe <= ~tx_q[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_in)
                st_q <= ST_IDLE;
              else
                bit_q <= `DIR_BIT_FULL;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // dir_id_rom

// ---- tb/dir_id_rom_sva.sv ----
// port checker for the id store's two-wire read port
// assumes it is bound to dir_id_rom and sees only its ports
`timescale 1ns/1ps
module dir_id_rom_sva (
  input logic sys_clk,
  input logic reset,
  input logic id_store_supply,
  input logic id_store_serial_clk,
  input logic id_store_serial_data_i,
  input logic id_store_serial_data_o,
  input logic id_store_serial_data_oe,
  input logic id_store_busy
);
  logic [9:0] oe_cnt_q;
  wire scl = id_store_serial_clk;
  wire oe = id_store_serial_data_oe;
  wire busy = id_store_busy;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // a stuck low drive would hang the whole bus
  always @(posedge sys_clk)
    if (reset || !oe) oe_cnt_q <= 10'h000;
    else if (oe_cnt_q != 10'h3FF) oe_cnt_q <= oe_cnt_q + 10'h001;
  property p_od_low; id_store_serial_data_o == 1'b0; endproperty
  a_od_low: assert property (p_od_low)
    else $error("data output not held low");
  property p_oe_scl_low; $changed(oe) |-> !scl; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive moved while clock high");
  property p_oe_hold; $rose(scl) |=> $stable(oe) [*3]; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data drive moved after clock rise");
  property p_supply_off; !id_store_supply [*5] |-> !oe; endproperty
  a_supply_off: assert property (p_supply_off)
    else $error("drive while store unpowered");
  property p_reset_quiet; $fell(reset) |-> !oe && !busy; endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("port not quiet after reset");
  property p_oe_busy; oe |-> busy; endproperty
  a_oe_busy: assert property (p_oe_busy)
    else $error("drive while idle");
  property p_oe_bound; oe_cnt_q < 10'h258; endproperty
  a_oe_bound: assert property (p_oe_bound)
    else $error("data held low too long");
  property p_busy_supply; $rose(busy) |-> id_store_supply; endproperty
  a_busy_supply: assert property (p_busy_supply)
    else $error("transfer begun without supply");
  c_ack: cover property ($rose(oe));
  c_supply: cover property ($fell(id_store_supply));
  c_frame: cover property (busy ##1 !busy);
endmodule // dir_id_rom_sva
bind dir_id_rom dir_id_rom_sva u_dir_id_rom_sva (
  .sys_clk(sys_clk), .reset(reset), .id_store_supply(id_store_supply),
  .id_store_serial_clk(id_store_serial_clk),
  .id_store_serial_data_i(id_store_serial_data_i),
  .id_store_serial_data_o(id_store_serial_data_o),
  .id_store_serial_data_oe(id_store_serial_data_oe),
  .id_store_busy(id_store_busy));

// ---- tb/dir_host.sv ----
// two-wire host model reading the id store
// assumes the bench builds the open-drain data wire with a pull-up
`timescale 1ns/1ps
module dir_host (
  output logic scl,
  output logic pull,
  input logic sda
);
  // half clock period; raised to act as a slow host
  realtime hp = 62.5;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // data moves mid-low so it never races the clock fall
  task automatic start;
    #(hp / 2) pull = 1'b0;
    #(hp / 2) scl = 1'b1;
    #hp pull = 1'b1;
    #hp scl = 1'b0;
  endtask
  task automatic stop;
    #(hp / 2) pull = 1'b1;
    #(hp / 2) scl = 1'b1;
    #hp pull = 1'b0;
    #hp;
  endtask
  task automatic xbit(input logic b, output logic r);
    #(hp / 2) pull = !b;
    #(hp / 2) scl = 1'b1;
    #hp r = sda;
    scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ai,
                       output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(ai, ao);
  endtask
endmodule // dir_host

// ---- tb/tb.sv ----
// self-checking bench for the id store read port
// assumes dir_host as far side and a pull-up on the data wire
`timescale 1ns/1ps
module tb;
  localparam [15:0] VEN = 16'h1234; // arbitrary
  localparam [15:0] PRD = 16'h0001; // arbitrary
  localparam [47:0] TXT = "PANEL1";
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic supply = 1'b1;
  logic [7:0] rom [128];
  logic [7:0] q;
  logic ak;
  logic [31:0] rnd = 32'h0000_0e33;
  int ptr, error_cnt, checks, cyc;
  wire scl, pull, sda_o, oe, busy;
  wire sda = !(pull | oe);
  dir_id_rom #(.VENDOR_ID(VEN), .PRODUCT_CODE(PRD), .MODEL_TEXT(TXT))
    u_dir_id_rom (.sys_clk(sys_clk), .reset(reset),
    .id_store_supply(supply), .id_store_serial_clk(scl),
    .id_store_serial_data_i(sda), .id_store_serial_data_o(sda_o),
    .id_store_serial_data_oe(oe), .id_store_busy(busy));
  dir_host u_dir_host (.scl(scl), .pull(pull), .sda(sda));
  initial forever #5 sys_clk = !sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chk_ack(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED ack exp %b got %b", exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp,
                          input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic build;
    logic [7:0] s;
    logic [175:0] a;
    logic [143:0] b;
    logic [103:0] c;
    a = 176'h0E0E_0103_801C_1578_0A34_8592_5553_9226_2050_5400_0800;
    b = 144'h6419_0040_4100_2630_1888_3600_1DD6_1000_0018;
    c = "Color LCD\n   ";
    s = 8'h00;
    for (int i = 0; i < 128; i++) rom[i] = 8'h00;
    for (int i = 1; i < 7; i++) rom[i] = 8'hFF;
    rom[8] = VEN[15:8];
    rom[9] = VEN[7:0];
    rom[7'h0A] = PRD[7:0];
    rom[7'h0B] = PRD[15:8];
    for (int i = 0; i < 22; i++) rom[7'h10 + i] = a[175 - 8 * i -: 8];
    for (int i = 7'h26; i < 7'h36; i++) rom[i] = 8'h01;
    for (int i = 0; i < 18; i++) rom[7'h36 + i] = b[143 - 8 * i -: 8];
    for (int d = 7'h48; d < 7'h6C; d += 7'h12) begin
      rom[d + 3] = 8'hFE;
      for (int i = 0; i < 6; i++) rom[d + 5 + i] = TXT[47 - 8 * i -: 8];
      for (int i = 11; i < 18; i++) rom[d + i] = 8'h20;
    end
    rom[7'h6F] = 8'hFC;
    for (int i = 0; i < 13; i++) rom[7'h71 + i] = c[103 - 8 * i -: 8];
    for (int i = 0; i < 127; i++) s = s + rom[i];
    rom[127] = 8'h00 - s;
  endtask
  // current-address read; the host refuses the last byte
  task automatic rd(input int n);
    u_dir_host.start;
    u_dir_host.xbyte(8'hA1, 1'b1, q, ak);
    chk_ack(1'b0, ak);
    chk_flag("busy", 1'b1, busy);
    for (int k = 0; k < n; k++) begin
      u_dir_host.xbyte(8'hFF, k == n - 1, q, ak);
      chk_byte("rom byte", rom[ptr], q);
      ptr = (ptr + 1) % 128;
    end
    u_dir_host.stop;
    chk_flag("busy", 1'b0, busy);
  endtask
  // word address, then n data bytes that the store throws away
  task automatic wr(input logic [7:0] a, input int n);
    u_dir_host.start;
    u_dir_host.xbyte(8'hA0, 1'b1, q, ak);
    chk_ack(1'b0, ak);
    for (int k = 0; k <= n; k++) begin
      u_dir_host.xbyte(k ? rnd[7:0] : a, 1'b1, q, ak);
      chk_ack(1'b0, ak);
    end
    ptr = a;
  endtask
  task automatic nak(input logic [7:0] a);
    u_dir_host.start;
    u_dir_host.xbyte(a, 1'b1, q, ak);
    chk_ack(1'b1, ak);
    chk_flag("busy", 1'b0, busy);
    u_dir_host.stop;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      test_done;
    end
  end
  initial begin
    build;
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge sys_clk);
    ptr = 0;
    rd(16);
    rd(22);
    rd(34);
    rd(57);
    rnd = lfsr(rnd);
    wr(8'h10, 1);
    u_dir_host.stop;
    // written data must not move the read pointer
    rd(1);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      u_dir_host.hp = (i % 2) ? 150.0 : 62.5;
      wr(i ? {1'b0, rnd[6:0]} : 8'h7F, 0);
      rd(2);
      rd(1);
    end
    nak(8'hA3);
    @(posedge sys_clk) #1 supply = 1'b0;
    repeat (8) @(posedge sys_clk);
    nak(8'hA1);
    @(posedge sys_clk) #1 supply = 1'b1;
    repeat (8) @(posedge sys_clk);
    test_done;
  end
endmodule // tb
